//--- logic/lndc_diag_node.sv
// Purpose: Slave-side decoder of diagnostic master requests and builder of slave responses.
// Assumes: A LIN frame engine outside delivers header identifiers and received bytes, and pulls
//          response bytes one at a time.
// Notes:   Only assign-NAD and assign-frame-identifier-range are serviced; others stay silent.
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - Each request or response carries eight data bytes after the header.
// - Diagnostic frames always use the classic checksum after the last data byte.
// - Identifier 0x3C is a master request; 0x7D asks this node for a response.
// - Bytes are address, PCI, service, then five data bytes, both directions.
// - PCI high nibble zero is a single PDU of at most five payload bytes.
// - PCI high nibble one opens a multi-PDU message; consecutive PDUs follow.
// - PCI high nibble two is a consecutive PDU with a wrapping counter.
// - Unused data bytes are filled with all ones.
// - Services are accepted only in the compatibility modes that allow them.
// - Assign-NAD is answered positively only when address, maker and function codes match.
// - Positive assign-NAD answer: initial address, PCI 0x01, 0xF0, fill.
// - Negative assign-NAD answer: initial address, 0x03, 0x7F, 0xB0, 0x11, fill.
// - The replacement address is used afterwards and lost at reset.
// - With function code 0x0001 assign-NAD is not supported.
// - Assign-NAD to broadcast address 0x7F is recognised in modes 2.0 and 2.1.
// - Range request writes new identifiers for up to four indices from the start index, stopping at index 4.
// - In 2.1 a proper range request gets PCI 0x01, 0xF7, fill.
// - In 2.0 with function code 0x0001 a range request is refused negatively.
// - Checksum adds bytes with end-around carry, then inverts.
// - Index 0 is reserved; indices 1 to 4 select the four signal frames.
// - Node address, initial address and mode are loaded from configuration.
module lndc_diag_node (
   input  wire logic                                  clock,                 // System clock, 100 MHz.
   input  wire logic                                  arst_n,                // Asynchronous reset, active low.
   input  wire logic                                  cfg_load,              // Pulse: take configuration word.
   input  wire lndc_pkg::lndc_cfg_t                   cfg,                   // Configuration word.
   input  wire logic [15:0]                           maker_code,            // Supplier code of this node.
   input  wire logic [15:0]                           product_function_code, // Function code of this node.
   input  wire logic                                  hdr_valid,             // Pulse: header received.
   input  wire logic [7:0]                            hdr_pid,               // Protected identifier of header.
   input  wire logic                                  rx_valid,              // Pulse: response byte received.
   input  wire logic [7:0]                            rx_byte,               // Received byte.
   input  wire logic                                  tx_req,                // Pulse: next response byte wanted.
   output logic                                       tx_valid,              // Pulse: tx_byte is valid.
   output logic [7:0]                                 tx_byte,               // Response byte.
   output logic [7:0]                                 node_address,          // Current node address.
   output logic [lndc_pkg::NUM_FRAMES-1:0][7:0]       frame_pid,             // Signal frame identifiers.
   output logic                                       pid_update             // Pulse: identifiers rewritten.
);
   import lndc_pkg::*;

   // ----------------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------------
   logic                rst_meta;
   logic                rst_n;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   function automatic logic [7:0] csum_add(input logic [7:0] acc, input logic [7:0] b);
      logic [8:0] s;
      s = {1'b0, acc} + {1'b0, b};
      return s[7:0] + {7'h00, s[8]};
   endfunction : csum_add

   function automatic logic [7:0][7:0] make_resp(input logic [7:0] nad, input logic [7:0] pci,
                                                 input logic [7:0] rsid, input logic [7:0] d1,
                                                 input logic [7:0] d2);
      logic [7:0][7:0] r;
      r    = {8{FILL_BYTE}};
      r[0] = nad;
      r[1] = pci;
      r[2] = rsid;
      r[3] = d1;
      r[4] = d2;
      return r;
   endfunction : make_resp

   lndc_state_t         state;
   logic [3:0]          cnt;
   logic [7:0]          sum;
   logic [7:0][7:0]     rx_bytes;
   logic [7:0][7:0]     resp;
   logic [7:0][7:0]     next_resp;
   logic [NUM_FRAMES-1:0][7:0] next_frame_pid;
   logic                req_done;
   logic                pending;
   logic                next_respond;
   logic                do_assign;
   logic                do_range;
   logic [7:0]          init_nad;
   lndc_mode_t          mode;

   // ----------------------------------------------------------------------
   // Frame sequencing
   // ----------------------------------------------------------------------
   wire logic hdr_req  = hdr_valid && hdr_pid == PID_MASTER_REQ;
   wire logic hdr_resp = hdr_valid && hdr_pid == PID_SLAVE_RESP && pending;
   wire logic rx_last  = state == ST_RECV && rx_valid && cnt == PDU_BYTES;
   wire logic tx_last  = state == ST_SEND && tx_req && cnt == PDU_BYTES;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         cnt   <= 4'h0;
         sum   <= 8'h00;
      end else if (hdr_req || hdr_resp) begin
         state <= hdr_req ? ST_RECV : ST_SEND;
         cnt   <= 4'h0;
         sum   <= 8'h00;
      end else begin
         unique case (state)
            ST_IDLE: begin
            end
            ST_RECV: begin
               if (rx_valid) begin
                  cnt <= cnt + 4'h1;
                  sum <= csum_add(sum, rx_byte);
                  if (cnt == PDU_BYTES) begin
                     state <= ST_IDLE;
                  end
               end
            end
            ST_SEND: begin
               if (tx_req) begin
                  cnt <= cnt + 4'h1;
                  sum <= csum_add(sum, resp[cnt[2:0]]);
                  if (cnt == PDU_BYTES) begin
                     state <= ST_IDLE;
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Request capture
   // ----------------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rx_bytes <= '0;
         req_done <= 1'b0;
      end else begin
         if (state == ST_RECV && rx_valid && cnt < PDU_BYTES) begin
            rx_bytes[cnt[2:0]] <= rx_byte;
         end
         // The inverted data sum must equal the received checksum byte.
         req_done <= rx_last && rx_byte == ~sum;
      end
   end

   // ----------------------------------------------------------------------
   // Service decode
   // ----------------------------------------------------------------------
   wire logic [7:0] q_nad   = rx_bytes[0];
   wire logic [7:0] q_pci   = rx_bytes[1];
   wire logic [7:0] q_sid   = rx_bytes[2];
   wire logic [7:0] q_start = rx_bytes[3];
   // Multi-PDU types are not decoded and not serviced: no supported service needs them.
   // The length nibble counts the service byte as well as up to five data bytes.
   wire logic q_single = q_pci[7:4] == single_pdu_type && q_pci[3:0] <= SF_MAX_LEN + 4'h1;
   wire logic q_mine   = q_nad == node_address;
   wire logic q_bcast  = q_nad == NAD_BROADCAST;
   wire logic fc_restr = product_function_code == FC_RESTRICTED;
   wire logic ids_ok   = {rx_bytes[4], rx_bytes[3]} == maker_code &&
                         {rx_bytes[6], rx_bytes[5]} == product_function_code;
   wire logic mode_nad = mode == LNDC_MODE_20 || mode == LNDC_MODE_21;
   wire logic index_ok = q_start >= FRAME_INDEX_FIRST && q_start <= FRAME_INDEX_LAST;

   always_comb begin
      next_respond = 1'b0;
      do_assign    = 1'b0;
      do_range     = 1'b0;
      next_resp    = make_resp(node_address, PCI_POSITIVE, FILL_BYTE, FILL_BYTE, FILL_BYTE);
      if (q_sid == SID_ASSIGN_NAD && q_single && (q_mine || q_bcast) && mode_nad) begin
         if (fc_restr) begin
            next_respond = 1'b1;
            next_resp    = make_resp(init_nad, PCI_NEGATIVE, RSID_NEGATIVE, SID_ASSIGN_NAD,
                                     NRC_NOT_SUPPORTED);
         end else if (q_pci == PCI_REQ_LEN6 && ids_ok) begin
            do_assign    = 1'b1;
            next_respond = 1'b1;
            next_resp    = make_resp(init_nad, PCI_POSITIVE, RSID_ASSIGN_NAD_OK,
                                     FILL_BYTE, FILL_BYTE);
         end
      end else if (q_sid == SID_ASSIGN_RANGE && q_single && q_mine) begin
         if (mode == LNDC_MODE_21 && q_pci == PCI_REQ_LEN6 && index_ok) begin
            do_range     = 1'b1;
            next_respond = 1'b1;
            next_resp    = make_resp(node_address, PCI_POSITIVE, RSID_RANGE_OK,
                                     FILL_BYTE, FILL_BYTE);
         end else if (mode == LNDC_MODE_20 && fc_restr) begin
            next_respond = 1'b1;
            next_resp    = make_resp(node_address, PCI_NEGATIVE, RSID_NEGATIVE,
                                     SID_ASSIGN_RANGE, NRC_NOT_SUPPORTED);
         end
      end
   end

   // Slot j holds frame index j+1; data bytes 2..5 carry start..start+3.
   always_comb begin
      next_frame_pid = frame_pid;
      for (int j = 0; j < NUM_FRAMES; j++) begin
         if (int'(q_start) <= j + 1 && j + 1 < int'(q_start) + NUM_FRAMES) begin
            next_frame_pid[j] = rx_bytes[3'(j + 5 - int'(q_start))];
         end
      end
   end

   // ----------------------------------------------------------------------
   // Node configuration state
   // ----------------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         node_address <= NAD_RST;
         init_nad     <= NAD_RST;
         mode         <= MODE_RST;
      end else if (cfg_load) begin
         node_address <= cfg.node_address;
         init_nad     <= cfg.initial_node_address;
         mode         <= cfg.mode;
      end else if (req_done && do_assign) begin
         node_address <= rx_bytes[7];
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         frame_pid  <= {NUM_FRAMES{PID_UNUSED}};
         pid_update <= 1'b0;
      end else begin
         pid_update <= req_done && do_range;
         if (cfg_load) begin
            frame_pid <= cfg.frame_pid;
         end else if (req_done && do_range) begin
            frame_pid <= next_frame_pid;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Response staging and transmit
   // ----------------------------------------------------------------------
   // A new request drops any unsent answer; a fresh answer wins over a clear in the same cycle.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pending <= 1'b0;
         resp    <= {8{FILL_BYTE}};
      end else begin
         if (hdr_req || tx_last) begin
            pending <= 1'b0;
         end
         if (req_done && next_respond) begin
            pending <= 1'b1;
            resp    <= next_resp;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tx_valid <= 1'b0;
         tx_byte  <= 8'h00;
      end else begin
         tx_valid <= state == ST_SEND && tx_req;
         if (state == ST_SEND && tx_req) begin
            tx_byte <= (cnt == PDU_BYTES) ? ~sum : resp[cnt[2:0]];
         end
      end
   end

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   logic [3:0] h_cnt;
   logic [7:0] h_sum;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         h_cnt <= 4'h0;
         h_sum <= 8'h00;
      end else if (hdr_valid) begin
         h_cnt <= 4'h0;
         h_sum <= 8'h00;
      end else if (tx_valid) begin
         h_cnt <= h_cnt + 4'h1;
         h_sum <= csum_add(h_sum, tx_byte);
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   sequence s_bad_sum;
      rx_last && rx_byte != ~sum;
   endsequence
   sequence s_assign;
      req_done && do_assign;
   endsequence

   property p_tx_length;
      tx_valid |-> h_cnt <= PDU_BYTES;
   endproperty
   a_tx_length: assert property (p_tx_length) else $error("more than nine response bytes");

   property p_tx_checksum;
      tx_valid && h_cnt == PDU_BYTES |-> tx_byte == ~h_sum;
   endproperty
   a_tx_checksum: assert property (p_tx_checksum) else $error("bad response checksum");

   property p_tx_fill;
      tx_valid && h_cnt >= 4'h5 && h_cnt <= 4'h7 |-> tx_byte == FILL_BYTE;
   endproperty
   a_tx_fill: assert property (p_tx_fill) else $error("unused byte not filled");

   property p_send_start;
      hdr_resp && !hdr_req |=> state == ST_SEND && cnt == 4'h0;
   endproperty
   a_send_start: assert property (p_send_start) else $error("response header not served");

   property p_assign;
      s_assign |=> node_address == rx_bytes[7] && pending && resp[2] == RSID_ASSIGN_NAD_OK
                   && resp[0] == init_nad;
   endproperty
   a_assign: assert property (p_assign) else $error("address assignment wrong");

   property p_broadcast;
      req_done && q_sid == SID_ASSIGN_NAD && q_bcast && q_pci == PCI_REQ_LEN6 && ids_ok
      && mode_nad && !fc_restr |-> do_assign;
   endproperty
   a_broadcast: assert property (p_broadcast) else $error("broadcast assign ignored");

   property p_restricted;
      req_done && q_sid == SID_ASSIGN_NAD && fc_restr && (q_mine || q_bcast) && q_single
      && mode_nad |-> !do_assign ##1 resp[1] == PCI_NEGATIVE && resp[3] == SID_ASSIGN_NAD
      && resp[4] == NRC_NOT_SUPPORTED;
   endproperty
   a_restricted: assert property (p_restricted) else $error("restricted assign not refused");

   property p_bad_sum;
      s_bad_sum |=> !req_done ##1 !pending;
   endproperty
   a_bad_sum: assert property (p_bad_sum) else $error("bad checksum request answered");

   property p_range;
      req_done && do_range |=> pid_update && resp[2] == RSID_RANGE_OK && pending;
   endproperty
   a_range: assert property (p_range) else $error("range request not applied");
endmodule : lndc_diag_node

`default_nettype wire

//--- common/lndc_pkg.sv
// Purpose: Shared constants and types for the diagnostic node configuration handler.
// Assumes: Eight-byte diagnostic PDUs followed by one classic checksum byte.
// Notes:   Mode codes and reset values are local encodings of the configuration word.
package lndc_pkg;
   // ----------------------------------------------------------------------
   // Frame identifiers, services and answers
   // ----------------------------------------------------------------------
   localparam logic [7:0]  PID_MASTER_REQ     = 8'h3c;
   localparam logic [7:0]  PID_SLAVE_RESP     = 8'h7d;
   localparam logic [7:0]  SID_ASSIGN_NAD     = 8'hb0;
   localparam logic [7:0]  SID_ASSIGN_RANGE   = 8'hb7;
   localparam logic [7:0]  RSID_ASSIGN_NAD_OK = 8'hf0;
   localparam logic [7:0]  RSID_RANGE_OK      = 8'hf7;
   localparam logic [7:0]  RSID_NEGATIVE      = 8'h7f;
   localparam logic [7:0]  NRC_NOT_SUPPORTED  = 8'h11;
   localparam logic [7:0]  PCI_REQ_LEN6       = 8'h06;
   localparam logic [7:0]  PCI_POSITIVE       = 8'h01;
   localparam logic [7:0]  PCI_NEGATIVE       = 8'h03;
   localparam logic [7:0]  FILL_BYTE          = 8'hff;
   localparam logic [7:0]  NAD_BROADCAST      = 8'h7f;
   localparam logic [15:0] FC_RESTRICTED      = 16'h0001;
   // ----------------------------------------------------------------------
   // PDU layout
   // ----------------------------------------------------------------------
   localparam logic [3:0]  PDU_BYTES          = 4'h8;
   localparam logic [3:0]  single_pdu_type    = 4'h0;
   localparam logic [3:0]  first_pdu_type     = 4'h1;
   localparam logic [3:0]  consecutive_pdu_type = 4'h2;
   localparam logic [3:0]  SF_MAX_LEN         = 4'h5;
   localparam int          NUM_FRAMES         = 4;
   localparam logic [7:0]  FRAME_INDEX_FIRST  = 8'h01;
   localparam logic [7:0]  FRAME_INDEX_LAST   = 8'h04;
   // ----------------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------------
   localparam logic [7:0]  PID_UNUSED         = 8'h40;
   localparam logic [7:0]  NAD_RST            = 8'h00;

   typedef enum logic [1:0] {
      LNDC_MODE_13 = 2'h0,
      LNDC_MODE_20 = 2'h1,
      LNDC_MODE_21 = 2'h2
   } lndc_mode_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RECV = 3'b010,
      ST_SEND = 3'b100
   } lndc_state_t;

   typedef struct packed {
      logic [7:0]                       node_address;
      logic [7:0]                       initial_node_address;
      lndc_mode_t                       mode;
      logic [NUM_FRAMES-1:0][7:0]       frame_pid;
   } lndc_cfg_t;

   localparam lndc_mode_t  MODE_RST           = LNDC_MODE_13;
endpackage : lndc_pkg

//--- tb/lndc_master_model.sv
// Purpose: Behavioural bus master that sends diagnostic requests and collects node answers.
// Assumes: The frame engine hands bytes one per cycle; the model has no bit timing.
// Notes:   Released rx_byte shows the inverse of its last value; hdr_pid keeps a stale copy.
`timescale 1ns/1ns
`default_nettype none
module lndc_master_model (
   input  wire logic       clock,     // System clock.
   output logic            hdr_valid, // Header pulse.
   output logic [7:0]      hdr_pid,   // Header identifier.
   output logic            rx_valid,  // Byte pulse towards the node.
   output logic [7:0]      rx_byte,   // Byte towards the node.
   output logic            tx_req,    // Answer byte request.
   input  wire logic       tx_valid,  // Answer byte strobe.
   input  wire logic [7:0] tx_byte    // Answer byte.
);
   import lndc_pkg::*;
   initial begin
      hdr_valid = 1'b0;
      hdr_pid   = 8'h00;
      rx_valid  = 1'b0;
      rx_byte   = 8'h00;
      tx_req    = 1'b0;
   end
   // The carry is folded back at every step so the sum never leaves eight bits.
   function automatic logic [7:0] csum(input logic [7:0] b [8]);
      logic [8:0] s;
      s = 9'h000;
      for (int i = 0; i < 8; i++) begin
         s = {1'b0, s[7:0]} + {1'b0, b[i]};
         if (s[8]) s = s - 9'h0ff;
      end
      return ~s[7:0];
   endfunction : csum
   task automatic send(input logic [7:0] b [8], input logic bad);
      @(posedge clock);
      hdr_valid <= 1'b1;
      hdr_pid   <= PID_MASTER_REQ;
      for (int i = 0; i < 9; i++) begin
         @(posedge clock);
         hdr_valid <= 1'b0;
         rx_valid  <= 1'b1;
         rx_byte   <= (i < 8) ? b[i] : csum(b) ^ {7'h00, bad};
      end
      @(posedge clock);
      rx_valid <= 1'b0;
      rx_byte  <= ~rx_byte;
      repeat (3) @(posedge clock);
   endtask : send
   task automatic fetch(output logic [7:0] r [9], output int n);
      n = 0;
      @(posedge clock);
      hdr_valid <= 1'b1;
      hdr_pid   <= PID_SLAVE_RESP;
      @(posedge clock);
      hdr_valid <= 1'b0;
      tx_req    <= 1'b1;
      for (int i = 0; i < 9; i++) begin
         @(posedge clock);
         if (i == 8) tx_req <= 1'b0;
         #1;
         if (tx_valid === 1'b1) begin
            r[n] = tx_byte;
            n++;
         end
      end
      @(posedge clock);
   endtask : fetch
endmodule : lndc_master_model
`default_nettype wire

//--- tb/tb.sv
// Purpose: Self-checking bench of the diagnostic node handler against a master model.
// Assumes: Answers are read back with a fresh answer header after each request.
// Notes:   Seeded random node addresses, codes and identifiers among fixed corner cases.
`timescale 1ns/1ns
`default_nettype none
module tb;
   import lndc_pkg::*;
   logic                       clock, arst_n, cfg_load, hdr_valid, rx_valid, tx_req, tx_valid, pid_update;
   logic [7:0]                 hdr_pid, rx_byte, tx_byte, node_address, nad, nn;
   logic [15:0]                maker_code, product_function_code;
   lndc_cfg_t                  cfg;
   logic [NUM_FRAMES-1:0][7:0] frame_pid;
   logic [31:0]                p;
   logic [7:0]                 ep [4];
   logic [7:0]                 fb [8];
   int                         n_fail, samples_checked, seed, n_upd;
   lndc_diag_node dut (.clock(clock), .arst_n(arst_n), .cfg_load(cfg_load), .cfg(cfg),
      .maker_code(maker_code), .product_function_code(product_function_code), .hdr_valid(hdr_valid),
      .hdr_pid(hdr_pid), .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_req(tx_req), .tx_valid(tx_valid),
      .tx_byte(tx_byte), .node_address(node_address), .frame_pid(frame_pid), .pid_update(pid_update));
   lndc_master_model m (.clock(clock), .hdr_valid(hdr_valid), .hdr_pid(hdr_pid), .rx_valid(rx_valid),
      .rx_byte(rx_byte), .tx_req(tx_req), .tx_valid(tx_valid), .tx_byte(tx_byte));
   always #5 clock = ~clock;
   // The update pulse is counted so that refused requests can be shown not to raise it.
   always @(posedge clock) begin
      if (pid_update === 1'b1) n_upd++;
   end
   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : complete_run
   task automatic load(input lndc_mode_t md);
      @(posedge clock);
      cfg_load <= 1'b1;
      cfg      <= '{nad, 8'h33, md, {4{PID_UNUSED}}};
      @(posedge clock);
      cfg_load <= 1'b0;
      @(posedge clock);
      for (int k = 0; k < 4; k++) ep[k] = PID_UNUSED;
   endtask : load
   task automatic req(input logic [7:0] a, sid, d1, d2, d3, d4, d5, input logic bad);
      logic [7:0] b [8];
      b = '{a, PCI_REQ_LEN6, sid, d1, d2, d3, d4, d5};
      m.send(b, bad);
   endtask : req
   task automatic nad_req(input logic [7:0] a, mk, input logic bad);
      req(a, SID_ASSIGN_NAD, mk, maker_code[15:8], product_function_code[7:0],
          product_function_code[15:8], nn, bad);
   endtask : nad_req
   // A zero PCI stands for an answer that must not come at all.
   task automatic expect_resp(input string t, input logic [7:0] a, pci, rsid, d1, d2);
      logic [7:0] e [8];
      logic [7:0] r [9];
      int         n;
      e = '{a, pci, rsid, d1, d2, FILL_BYTE, FILL_BYTE, FILL_BYTE};
      m.fetch(r, n);
      check("resp_count", n[7:0], (pci == 8'h00) ? 8'h00 : 8'h09);
      for (int i = 0; i < n && i < 8; i++) check("resp_byte", r[i], e[i]);
      if (n == 9) check("resp_csum", r[8], m.csum(e));
      $display("test %s done", t);
   endtask : expect_resp
   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial begin
      #200000;
      n_fail++;
      complete_run();
   end
   initial begin
      seed = 5;
      clock = 1'b0;
      arst_n = 1'b0;
      cfg_load = 1'b0;
      cfg = '0;
      n_fail = 0;
      samples_checked = 0;
      p = $random(seed);
      maker_code = p[15:0];
      product_function_code = p[31:16] | 16'h0100;
      p = $random(seed);
      nad = 8'h01 + (p[7:0] & 8'h3f);
      nn = 8'h41 + (p[15:8] & 8'h1f);
      repeat (4) @(posedge clock);
      arst_n <= 1'b1;
      repeat (3) @(posedge clock);
      load(LNDC_MODE_21);
      check("nad_load", node_address, nad);
      nad_req(nad, ~maker_code[7:0], 1'b0);
      expect_resp("wrong_maker", 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      nad_req(nad, maker_code[7:0], 1'b1);
      expect_resp("bad_csum", 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      check("nad_kept", node_address, nad);
      nad_req(nad, maker_code[7:0], 1'b0);
      expect_resp("assign", 8'h33, PCI_POSITIVE, RSID_ASSIGN_NAD_OK, FILL_BYTE, FILL_BYTE);
      check("nad_new", node_address, nn);
      req(nad, SID_ASSIGN_RANGE, 8'h01, 8'h11, 8'h22, 8'h33, 8'h44, 1'b0);
      expect_resp("old_nad", 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      nn = nad;
      nad_req(NAD_BROADCAST, maker_code[7:0], 1'b0);
      expect_resp("broadcast", 8'h33, PCI_POSITIVE, RSID_ASSIGN_NAD_OK, FILL_BYTE, FILL_BYTE);
      check("nad_back", node_address, nad);
      for (int s = 1; s <= 4; s++) begin
         p = $random(seed);
         req(nad, SID_ASSIGN_RANGE, s[7:0], p[7:0], p[15:8], p[23:16], p[31:24], 1'b0);
         for (int k = 0; k < 4; k++) if (s - 1 + k < 4) ep[s-1+k] = p[8*k +: 8];
         expect_resp("range", nad, PCI_POSITIVE, RSID_RANGE_OK, FILL_BYTE, FILL_BYTE);
         for (int k = 0; k < 4; k++) check("frame_pid", frame_pid[k], ep[k]);
      end
      fb = '{nad, {first_pdu_type, 4'h6}, SID_ASSIGN_RANGE, 8'h01, 8'h05, 8'h06, 8'h07, 8'h08};
      m.send(fb, 1'b0);
      expect_resp("first_pdu", 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      fb[1] = {consecutive_pdu_type, 4'h1};
      m.send(fb, 1'b0);
      expect_resp("cons_pdu", 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      req(nad, SID_ASSIGN_RANGE, 8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 1'b0);
      expect_resp("index0", 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      for (int k = 0; k < 4; k++) check("frame_pid", frame_pid[k], ep[k]);
      check("pid_update", n_upd[7:0], 8'h04);
      product_function_code <= FC_RESTRICTED;
      load(LNDC_MODE_20);
      nad_req(nad, maker_code[7:0], 1'b0);
      expect_resp("nad_neg", 8'h33, PCI_NEGATIVE, RSID_NEGATIVE, SID_ASSIGN_NAD, NRC_NOT_SUPPORTED);
      req(nad, SID_ASSIGN_RANGE, 8'h01, 8'h11, 8'h22, 8'h33, 8'h44, 1'b0);
      expect_resp("range_neg", nad, PCI_NEGATIVE, RSID_NEGATIVE, SID_ASSIGN_RANGE, NRC_NOT_SUPPORTED);
      load(LNDC_MODE_13);
      nad_req(nad, maker_code[7:0], 1'b0);
      expect_resp("mode13", 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      arst_n <= 1'b0;
      repeat (2) @(posedge clock);
      check("nad_reset", node_address, NAD_RST);
      complete_run();
   end
endmodule : tb
`default_nettype wire
